/* File: include/bsf_pkg.sv */
// shared constants and types of the branch, skip and compare unit
package bsf_pkg;
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] PC_OFF = 8'h04;
   localparam logic [7:0] STATUS_REG_OFF = 8'h08;
   localparam logic [7:0] SP_OFF = 8'h0c;
   localparam logic [7:0] STAT_OFF = 8'h10;
   localparam int CTRL_EN_BIT = 0;
   localparam int STAT_CYC_LSB = 0;
   localparam int STAT_BUSY_BIT = 8;
   localparam logic CTRL_EN_RESET = 1'b1;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] SP_RESET = 16'hffff;
   localparam logic [7:0] STATUS_REG_RESET = 8'h00;
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;
   localparam logic [2:0] CYC_SHORT = 3'h1;
   localparam logic [2:0] CYC_BR_TAKEN = 3'h2;
   localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
   localparam logic [2:0] CYC_SKIP_TWO = 3'h3;
   localparam logic [2:0] CYC_CALL = 3'h3;
   localparam logic [2:0] CYC_RET = 3'h4;
   localparam logic [15:0] SKIP_ONE_WORD = 16'h0002;
   localparam logic [15:0] SKIP_TWO_WORD = 16'h0003;

   typedef enum logic [4:0] {
      OP_NONE, OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
      OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET, OP_COMPARE_REGS, OP_COMPARE_REGS_CARRY,
      OP_COMPARE_IMMEDIATE, OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_EQUAL,
      OP_BRANCH_NOT_EQUAL, OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR,
      OP_BRANCH_SAME_HIGHER, OP_BRANCH_LOWER, OP_BRANCH_MINUS, OP_BRANCH_PLUS,
      OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT, OP_BRANCH_HALFCARRY_SET,
      OP_BRANCH_HALFCARRY_CLEAR, OP_BRANCH_TBIT_SET, OP_BRANCH_TBIT_CLEAR,
      OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR, OP_INDIRECT_CALL,
      OP_RELATIVE_CALL, OP_SUB_RETURN, OP_INTERRUPT_RETURN
   } bsf_op_t;

   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} bsf_state_t;

   typedef struct packed {
      bsf_op_t op;
      logic [7:0] rd_val;
      logic [7:0] rr_val;
      logic [7:0] imm;
      logic [2:0] bsel;
      logic [7:0] io_val;
      logic [11:0] offset;
      logic [15:0] zptr;
      logic next_two_word;
   } bsf_ins_t;

   typedef struct packed {
      logic [15:0] addr;
      logic we;
      logic [7:0] wdata;
   } bsf_stk_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } bsf_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } bsf_apb_rsp_t;
endpackage

/* File: hdl/bsf_cmp.sv */
// compare subtractor producing updated status flags
`timescale 1ns/1ns
module bsf_cmp (
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic use_carry,
   input wire logic [7:0] status_in,
   output logic [7:0] status_out
);
   import bsf_pkg::*;
   logic [8:0] diff;
   logic [7:0] r;
   logic v;
   assign diff = {1'b0, a} - {1'b0, b} - {8'h00, use_carry & status_in[FLAG_C]};
   assign r = diff[7:0];
   assign v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
   always_comb
   begin
      status_out = status_in;
      status_out[FLAG_C] = diff[8];
      status_out[FLAG_Z] = (r == 8'h00) & (~use_carry | status_in[FLAG_Z]);
      status_out[FLAG_N] = r[7];
      status_out[FLAG_V] = v;
      status_out[FLAG_S] = r[7] ^ v;
      status_out[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
   end
endmodule

/* File: hdl/bsf_cond.sv */
// condition evaluation for skips and relative branches
`timescale 1ns/1ns
module bsf_cond (
   input wire bsf_pkg::bsf_op_t op,
   input wire logic [7:0] status,
   input wire logic [7:0] rd_val,
   input wire logic [7:0] rr_val,
   input wire logic [2:0] bsel,
   input wire logic [7:0] io_val,
   output logic is_skip,
   output logic is_branch,
   output logic take
);
   import bsf_pkg::*;
   always_comb
   begin
      is_skip = 1'b0;
      is_branch = 1'b1;
      take = 1'b0;
      case (op)
         OP_COMPARE_SKIP_EQUAL: take = (rd_val == rr_val);
         OP_SKIP_REG_BIT_CLEAR: take = ~rr_val[bsel];
         OP_SKIP_REG_BIT_SET: take = rr_val[bsel];
         OP_SKIP_IO_BIT_CLEAR: take = ~io_val[bsel];
         OP_SKIP_IO_BIT_SET: take = io_val[bsel];
         OP_BRANCH_FLAG_SET: take = status[bsel];
         OP_BRANCH_FLAG_CLEAR: take = ~status[bsel];
         OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: take = status[FLAG_C];
         OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER: take = ~status[FLAG_C];
         OP_BRANCH_EQUAL: take = status[FLAG_Z];
         OP_BRANCH_NOT_EQUAL: take = ~status[FLAG_Z];
         OP_BRANCH_MINUS: take = status[FLAG_N];
         OP_BRANCH_PLUS: take = ~status[FLAG_N];
         OP_BRANCH_SIGNED_GE: take = ~(status[FLAG_N] ^ status[FLAG_V]);
         OP_BRANCH_SIGNED_LT: take = status[FLAG_N] ^ status[FLAG_V];
         OP_BRANCH_HALFCARRY_SET: take = status[FLAG_H];
         OP_BRANCH_HALFCARRY_CLEAR: take = ~status[FLAG_H];
         OP_BRANCH_TBIT_SET: take = status[FLAG_T];
         OP_BRANCH_TBIT_CLEAR: take = ~status[FLAG_T];
         OP_BRANCH_OVERFLOW_SET: take = status[FLAG_V];
         OP_BRANCH_OVERFLOW_CLEAR: take = ~status[FLAG_V];
         default: is_branch = 1'b0;
      endcase
      if (op inside {OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
                     OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET})
      begin
         is_skip = 1'b1;
         is_branch = 1'b0;
      end
   end
endmodule

/* File: hdl/bsf_flow_unit.sv */
// program flow execution unit: compares, skips, branches, calls and returns
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ns
module bsf_flow_unit (
   input wire logic mclk,
   input wire logic rst_n,
   input wire bsf_pkg::bsf_apb_req_t apb_req,
   output bsf_pkg::bsf_apb_rsp_t apb_rsp,
   input wire logic ins_valid,
   input wire bsf_pkg::bsf_ins_t ins,
   output logic ins_ready,
   output logic done,
   output logic [2:0] done_cycles,
   output logic [15:0] pc,
   output logic [7:0] status,
   output bsf_pkg::bsf_stk_t stk,
   input wire logic [7:0] stk_rdata
);
   import bsf_pkg::*;

   bsf_state_t state_q;
   bsf_apb_rsp_t rsp_q;
   bsf_stk_t stk_q;
   logic [2:0] step_q;
   logic [2:0] ncyc_q;
   logic [2:0] done_cyc_q;
   logic [15:0] pc_q;
   logic [15:0] sp_q;
   logic [15:0] tgt_q;
   logic [15:0] ret_q;
   logic [7:0] status_q;
   logic [7:0] hi_q;
   logic [7:0] lo_q;
   logic call_q;
   logic pop_q;
   logic int_ret_q;
   logic done_q;
   logic ready_q;
   logic ctrl_en_q;

   logic accept;
   logic finish;
   logic idle_free;
   logic sw_wr;
   logic is_skip;
   logic is_branch;
   logic take;
   logic is_cmp;
   logic is_call;
   logic is_ret;
   logic [2:0] n_cyc;
   logic [15:0] tgt;
   logic [15:0] ret_addr;
   logic [15:0] rel_tgt;
   logic [7:0] cmp_b;
   logic [7:0] cmp_status;
   logic [31:0] rd_data;
   logic rd_hit;

   assign apb_rsp = rsp_q;
   assign stk = stk_q;
   assign ins_ready = ready_q;
   assign done = done_q;
   assign done_cycles = done_cyc_q;
   assign pc = pc_q;
   assign status = status_q;

   assign accept = ins_valid && ready_q;
   assign finish = (state_q == ST_RUN) && (step_q == ncyc_q - 3'h1);
   assign idle_free = (state_q == ST_IDLE) && !accept;
   assign sw_wr = apb_req.psel && apb_req.penable && rsp_q.pready && apb_req.pwrite;
   assign ret_addr = pc_q + 16'h0001;
   assign rel_tgt = pc_q + {{4{ins.offset[11]}}, ins.offset} + 16'h0001;
   assign cmp_b = (ins.op == OP_COMPARE_IMMEDIATE) ? ins.imm : ins.rr_val;

   bsf_cond u_cond (
      .op(ins.op),
      .status(status_q),
      .rd_val(ins.rd_val),
      .rr_val(ins.rr_val),
      .bsel(ins.bsel),
      .io_val(ins.io_val),
      .is_skip(is_skip),
      .is_branch(is_branch),
      .take(take)
   );

   bsf_cmp u_cmp (
      .a(ins.rd_val),
      .b(cmp_b),
      .use_carry(ins.op == OP_COMPARE_REGS_CARRY),
      .status_in(status_q),
      .status_out(cmp_status)
   );

   // cycle count and next pc of the presented instruction
   always_comb
   begin
      n_cyc = CYC_SHORT;
      tgt = ret_addr;
      is_cmp = 1'b0;
      is_call = 1'b0;
      is_ret = 1'b0;
      if (is_skip && take)
      begin
         n_cyc = ins.next_two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE;
         tgt = pc_q + (ins.next_two_word ? SKIP_TWO_WORD : SKIP_ONE_WORD);
      end
      else if (is_branch && take)
      begin
         n_cyc = CYC_BR_TAKEN;
         tgt = rel_tgt;
      end
      case (ins.op)
         OP_COMPARE_REGS, OP_COMPARE_REGS_CARRY, OP_COMPARE_IMMEDIATE: is_cmp = 1'b1;
         OP_INDIRECT_CALL:
         begin
            n_cyc = CYC_CALL;
            tgt = ins.zptr;
            is_call = 1'b1;
         end
         OP_RELATIVE_CALL:
         begin
            n_cyc = CYC_CALL;
            tgt = rel_tgt;
            is_call = 1'b1;
         end
         OP_SUB_RETURN, OP_INTERRUPT_RETURN:
         begin
            n_cyc = CYC_RET;
            is_ret = 1'b1;
         end
         default: is_cmp = 1'b0;
      endcase
   end

   // sequencer for instructions longer than one cycle
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         step_q <= 3'h0;
         ncyc_q <= CYC_SHORT;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
               if (accept && n_cyc != CYC_SHORT)
               begin
                  state_q <= ST_RUN;
                  step_q <= 3'h1;
                  ncyc_q <= n_cyc;
               end
            ST_RUN:
               if (finish)
                  state_q <= ST_IDLE;
               else
                  step_q <= step_q + 3'h1;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // what a multi-cycle instruction does at its end
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tgt_q <= PC_RESET;
         ret_q <= PC_RESET;
         call_q <= 1'b0;
         pop_q <= 1'b0;
         int_ret_q <= 1'b0;
      end
      else if (accept)
      begin
         tgt_q <= tgt;
         ret_q <= ret_addr;
         call_q <= is_call;
         pop_q <= is_ret;
         int_ret_q <= (ins.op == OP_INTERRUPT_RETURN);
      end
   end

   // return address pops: high byte first, then low byte
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hi_q <= 8'h00;
         lo_q <= 8'h00;
      end
      else if (state_q == ST_RUN && pop_q)
      begin
         if (step_q == 3'h1)
            hi_q <= stk_rdata;
         if (step_q == 3'h2)
            lo_q <= stk_rdata;
      end
   end

   // stack port: push low at sp then high at sp-1
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         stk_q <= '0;
      else if (accept && is_call)
      begin
         stk_q.addr <= sp_q;
         stk_q.we <= 1'b1;
         stk_q.wdata <= ret_addr[7:0];
      end
      else if (accept && is_ret)
      begin
         stk_q.addr <= sp_q + 16'h0001;
         stk_q.we <= 1'b0;
      end
      else if (state_q == ST_RUN && step_q == 3'h1 && call_q)
      begin
         stk_q.addr <= sp_q - 16'h0001;
         stk_q.wdata <= ret_q[15:8];
      end
      else if (state_q == ST_RUN && step_q == 3'h1 && pop_q)
         stk_q.addr <= sp_q + 16'h0002;
      else
         stk_q.we <= 1'b0;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         pc_q <= PC_RESET;
      else if (accept && n_cyc == CYC_SHORT)
         pc_q <= tgt;
      else if (finish)
         pc_q <= pop_q ? {hi_q, lo_q} : tgt_q;
      else if (sw_wr && apb_req.paddr == PC_OFF && idle_free)
         pc_q <= apb_req.pwdata[15:0];
   end

   // hardware flag updates take priority over a software write
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         status_q <= STATUS_REG_RESET;
      else if (accept && is_cmp)
         status_q <= cmp_status;
      else if (finish && int_ret_q)
         status_q[FLAG_I] <= 1'b1;
      else if (sw_wr && apb_req.paddr == STATUS_REG_OFF && idle_free)
         status_q <= apb_req.pwdata[7:0];
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         sp_q <= SP_RESET;
      else if (finish && call_q)
         sp_q <= sp_q - 16'h0002;
      else if (finish && pop_q)
         sp_q <= sp_q + 16'h0002;
      else if (sw_wr && apb_req.paddr == SP_OFF && idle_free)
         sp_q <= apb_req.pwdata[15:0];
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_q <= 1'b0;
         done_cyc_q <= 3'h0;
         ready_q <= 1'b0;
      end
      else
      begin
         done_q <= (accept && n_cyc == CYC_SHORT) || finish;
         if (accept && n_cyc == CYC_SHORT)
            done_cyc_q <= n_cyc;
         else if (finish)
            done_cyc_q <= ncyc_q;
         ready_q <= ctrl_en_q &&
                    (((state_q == ST_IDLE) && !(accept && n_cyc != CYC_SHORT)) || finish);
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_en_q <= CTRL_EN_RESET;
      else if (sw_wr && apb_req.paddr == CTRL_OFF)
         ctrl_en_q <= apb_req.pwdata[CTRL_EN_BIT];
   end

   // register read mux
   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_hit = 1'b1;
      case (apb_req.paddr)
         CTRL_OFF: rd_data[CTRL_EN_BIT] = ctrl_en_q;
         PC_OFF: rd_data[15:0] = pc_q;
         STATUS_REG_OFF: rd_data[7:0] = status_q;
         SP_OFF: rd_data[15:0] = sp_q;
         STAT_OFF:
         begin
            rd_data[STAT_CYC_LSB +: 3] = done_cyc_q;
            rd_data[STAT_BUSY_BIT] = (state_q == ST_RUN);
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // apb answer: one wait state in every access phase
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rsp_q <= '0;
      else
      begin
         rsp_q.pready <= apb_req.psel && apb_req.penable && !rsp_q.pready;
         if (apb_req.psel && apb_req.penable && !rsp_q.pready)
         begin
            rsp_q.prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_data;
            rsp_q.pslverr <= !rd_hit;
         end
         else
         begin
            rsp_q.prdata <= 32'h0000_0000;
            rsp_q.pslverr <= 1'b0;
         end
      end
   end

   skip_equal_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && ins.op == OP_COMPARE_SKIP_EQUAL && ins.rd_val == ins.rr_val && !ins.next_two_word
      |-> ##2 done_q && pc_q == $past(pc_q, 2) + 16'h0002)
      else $error("equal compare skip wrong");

   skip_long_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && is_skip && take && ins.next_two_word
      |-> ##1 !done_q ##1 !done_q ##1 done_q && done_cyc_q == 3'h3)
      else $error("long skip cycle count wrong");

   noskip_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && ins.op == OP_SKIP_REG_BIT_CLEAR && ins.rr_val[ins.bsel]
      |=> done_q && pc_q == $past(pc_q) + 16'h0001 && done_cyc_q == 3'h1)
      else $error("register bit skip taken wrongly");

   io_skip_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && ins.op == OP_SKIP_IO_BIT_SET && ins.io_val[ins.bsel] && !ins.next_two_word
      |=> !ready_q ##1 done_q && pc_q == $past(pc_q, 2) + 16'h0002)
      else $error("io bit set skip wrong");

   cmp_flags_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && is_cmp |=> done_q && status_q == $past(cmp_status)
         && pc_q == $past(pc_q) + 16'h0001)
      else $error("compare flags or timing wrong");

   branch_taken_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && is_branch && take
      |-> ##2 done_q && done_cyc_q == 3'h2 && pc_q == $past(rel_tgt, 2))
      else $error("taken branch wrong");

   signed_ge_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && ins.op == OP_BRANCH_SIGNED_GE && (status_q[FLAG_N] ^ status_q[FLAG_V])
      |=> done_q && pc_q == $past(pc_q) + 16'h0001)
      else $error("signed branch taken wrongly");

   ind_call_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && ins.op == OP_INDIRECT_CALL
      |-> ##3 done_q && pc_q == $past(ins.zptr, 3) && status_q == $past(status_q, 3))
      else $error("indirect call wrong");

   push_ret_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && is_call |=> stk_q.we && {8'h00, stk_q.wdata} == ($past(ret_addr) & 16'h00ff)
         ##1 stk_q.we && stk_q.addr == $past(sp_q, 2) - 16'h0001
         && {stk_q.wdata, 8'h00} == ($past(ret_addr, 2) & 16'hff00))
      else $error("return address push wrong");

   int_return_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && ins.op == OP_INTERRUPT_RETURN && !status_q[FLAG_I]
      |-> ##4 done_q && status_q[FLAG_I] && sp_q == $past(sp_q, 4) + 16'h0002)
      else $error("interrupt return wrong");
endmodule

/* File: bench/test_bsf_flow_unit.sv */
// self-checking bench of the program flow unit
`timescale 1ns/1ns
module test_bsf_flow_unit;
   import bsf_pkg::*;
   logic mclk;
   logic rst_n;
   bsf_apb_req_t req;
   bsf_apb_rsp_t rsp;
   logic ins_valid;
   bsf_ins_t ins;
   logic ins_ready;
   logic done;
   logic [2:0] done_cycles;
   logic [15:0] pc;
   logic [7:0] status;
   bsf_stk_t stk;
   logic [7:0] stk_rdata;
   logic [7:0] stk_mem [256];
   int miscompares;
   int comparisons;
   logic [15:0] ep;
   logic [15:0] ra;
   logic [7:0] es;
   logic [7:0] v;
   logic t;
   int n;
   bsf_ins_t i;
   logic [7:0] pat [6] = '{8'h00, 8'hff, 8'h55, 8'haa, 8'h0c, 8'h08};
   logic [7:0] ca [5] = '{8'h10, 8'h00, 8'h80, 8'h7f, 8'h38};
   logic [7:0] cb [5] = '{8'h10, 8'h01, 8'h01, 8'hff, 8'h09};

   bsf_flow_unit u_dut (.mclk(mclk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
      .ins_valid(ins_valid), .ins(ins), .ins_ready(ins_ready), .done(done),
      .done_cycles(done_cycles), .pc(pc), .status(status), .stk(stk), .stk_rdata(stk_rdata));

   // stack memory answers combinationally
   assign stk_rdata = stk_mem[stk.addr[7:0]];
   always @(posedge mclk)
   begin
      if (stk.we)
         stk_mem[stk.addr[7:0]] <= stk.wdata;
   end

   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task close_out;
      if (miscompares == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, x, s);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int k;
      @(posedge mclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge mclk);
      req.penable <= 1'b1;
      k = 0;
      // pready is looked at on the rising edge that completes the access
      do
      begin
         @(posedge mclk);
         k++;
      end
      while (rsp.pready !== 1'b1 && k < 20);
      r = rsp.prdata;
      e = rsp.pslverr;
      req <= '0;
      chk("pready_wait", 32'(k < 20), 32'h1);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task rdc(input string nm, input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, r, x);
      chk("pslverr", {31'h0, e}, {31'h0, xe});
   endtask

   // issues one instruction and checks latency, pc, count and flags
   task run(input bsf_ins_t x, input logic [15:0] xp, input logic [2:0] xc, input logic [7:0] xs);
      int k;
      k = 0;
      do
      begin
         @(negedge mclk);
         k++;
      end
      while (ins_ready !== 1'b1 && k < 20);
      @(posedge mclk);
      ins_valid <= 1'b1;
      ins <= x;
      @(posedge mclk);
      ins_valid <= 1'b0;
      k = 0;
      do
      begin
         @(negedge mclk);
         k++;
      end
      while (done !== 1'b1 && k < 20);
      chk("latency", k, {29'h0, xc});
      chk("done_cycles", {29'h0, done_cycles}, {29'h0, xc});
      chk("pc", {16'h0, pc}, {16'h0, xp});
      chk("status", {24'h0, status}, {24'h0, xs});
      ep = xp;
   endtask

   function logic br_take(bsf_op_t op, logic [7:0] s, logic [2:0] b);
      case (op)
         OP_BRANCH_FLAG_SET: return s[b];
         OP_BRANCH_FLAG_CLEAR: return !s[b];
         OP_BRANCH_EQUAL: return s[FLAG_Z];
         OP_BRANCH_NOT_EQUAL: return !s[FLAG_Z];
         OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: return s[FLAG_C];
         OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER: return !s[FLAG_C];
         OP_BRANCH_MINUS: return s[FLAG_N];
         OP_BRANCH_PLUS: return !s[FLAG_N];
         OP_BRANCH_SIGNED_GE: return !(s[FLAG_N] ^ s[FLAG_V]);
         OP_BRANCH_SIGNED_LT: return s[FLAG_N] ^ s[FLAG_V];
         OP_BRANCH_HALFCARRY_SET: return s[FLAG_H];
         OP_BRANCH_HALFCARRY_CLEAR: return !s[FLAG_H];
         OP_BRANCH_TBIT_SET: return s[FLAG_T];
         OP_BRANCH_TBIT_CLEAR: return !s[FLAG_T];
         OP_BRANCH_OVERFLOW_SET: return s[FLAG_V];
         default: return !s[FLAG_V];
      endcase
   endfunction

   function logic [7:0] cmp_flags(logic [7:0] s, logic [7:0] a, logic [7:0] b, logic wc);
      logic [7:0] r;
      logic [7:0] o;
      r = a - b - {7'h0, wc & s[FLAG_C]};
      o = s;
      o[FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
      o[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      o[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      o[FLAG_N] = r[7];
      o[FLAG_Z] = (r == 8'h00) & (!wc | s[FLAG_Z]);
      o[FLAG_S] = o[FLAG_N] ^ o[FLAG_V];
      return o;
   endfunction

   initial
   begin
      rst_n = 1'b0;
      req = '0;
      ins_valid = 1'b0;
      ins = '0;
      miscompares = 0;
      comparisons = 0;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      chk("pc_reset", {16'h0, pc}, {16'h0, PC_RESET});
      chk("status_reset", {24'h0, status}, {24'h0, STATUS_REG_RESET});
      @(negedge mclk);
      chk("ready", {31'h0, ins_ready}, 32'h1);
      rdc("ctrl", CTRL_OFF, 32'h1, 1'b0);
      rdc("sp", SP_OFF, 32'hffff, 1'b0);
      rdc("unmapped", 8'h40, 32'h0, 1'b1);
      wr(PC_OFF, 32'h0100);
      ep = 16'h0100;
      rdc("pc_reg", PC_OFF, 32'h0100, 1'b0);
      wr(CTRL_OFF, 32'h0);
      // enable lands at the pready edge, ready follows one edge later
      repeat (2) @(negedge mclk);
      chk("ready_off", {31'h0, ins_ready}, 32'h0);
      wr(CTRL_OFF, 32'h1);
      for (int o = OP_BRANCH_FLAG_SET; o <= OP_BRANCH_OVERFLOW_CLEAR; o++)
      begin
         for (int p = 0; p < 6; p++)
         begin
            es = pat[p];
            wr(STATUS_REG_OFF, {24'h0, es});
            i = '0;
            i.op = bsf_op_t'(o);
            i.bsel = 3'(o + p);
            i.offset = p[0] ? 12'hffc : 12'h011;
            t = br_take(i.op, es, i.bsel);
            ra = t ? ep + {{4{i.offset[11]}}, i.offset} + 16'h1 : ep + 16'h1;
            n = t ? CYC_BR_TAKEN : CYC_SHORT;
            run(i, ra, 3'(n), es);
         end
      end
      for (int o = OP_COMPARE_SKIP_EQUAL; o <= OP_SKIP_IO_BIT_SET; o++)
      begin
         for (int p = 0; p < 4; p++)
         begin
            v = p[0] ? 8'h5a : 8'h5b;
            i = '0;
            i.op = bsf_op_t'(o);
            i.rr_val = v;
            i.io_val = v;
            i.rd_val = (o == OP_COMPARE_SKIP_EQUAL) ? 8'h5a : v;
            i.next_two_word = p[1];
            if (o == OP_COMPARE_SKIP_EQUAL)
               t = (i.rd_val == i.rr_val);
            else
               t = v[0] ^ (o == OP_SKIP_REG_BIT_CLEAR || o == OP_SKIP_IO_BIT_CLEAR);
            n = t ? (p[1] ? 3 : 2) : 1;
            run(i, ep + 16'(n), 3'(n), es);
         end
      end
      for (int o = OP_COMPARE_REGS; o <= OP_COMPARE_IMMEDIATE; o++)
      begin
         for (int p = 0; p < 5; p++)
         begin
            es = p[0] ? 8'h03 : 8'h00;
            wr(STATUS_REG_OFF, {24'h0, es});
            i = '0;
            i.op = bsf_op_t'(o);
            i.rd_val = ca[p];
            i.rr_val = cb[p];
            i.imm = cb[p];
            es = cmp_flags(es, ca[p], cb[p], o == OP_COMPARE_REGS_CARRY);
            run(i, ep + 16'h1, CYC_SHORT, es);
         end
      end
      es = 8'h12;
      wr(STATUS_REG_OFF, {24'h0, es});
      i = '0;
      i.op = OP_INDIRECT_CALL;
      i.zptr = 16'h2345;
      ra = ep + 16'h1;
      run(i, 16'h2345, CYC_CALL, es);
      rdc("sp_push", SP_OFF, 32'hfffd, 1'b0);
      i.op = OP_INTERRUPT_RETURN;
      es = es | 8'h80;
      run(i, ra, CYC_RET, es);
      rdc("sp_pop", SP_OFF, 32'hffff, 1'b0);
      i.op = OP_RELATIVE_CALL;
      i.offset = 12'h020;
      ra = ep + 16'h1;
      run(i, ep + 16'h21, CYC_CALL, es);
      i.op = OP_SUB_RETURN;
      run(i, ra, CYC_RET, es);
      close_out;
   end

   initial
   begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      close_out;
   end
endmodule
